// *** sim/reset_far_side_model.sv ***
// Far-side model: external reset pin driver and supply monitors.
`timescale 1ns/1ps

module reset_far_side_model (
  // Clock
  input  wire logic core_clk,
  // Bench commands
  input  wire logic pin_low_req,
  input  wire logic uv_req,
  input  wire logic lp_uv_req,
  // Device pin controls
  input  wire logic pin_pullup,
  input  wire logic pin_oe,
  input  wire logic pin_o,
  // Device inputs
  output logic      pin_level,
  output logic      brownout_det,
  output logic      lp_brownout_det
);
  // ==========================================================
  // Pin
  logic float_q = 1'b0;

  always @(posedge core_clk) begin
    float_q <= ~float_q;
  end

  // Released pin without pull-up wanders instead of holding its level
  assign pin_level = pin_low_req ? 1'b0 :
                     pin_oe      ? pin_o :
                     pin_pullup  ? 1'b1 : float_q;

  // ==========================================================
  // Supply monitors, asynchronous to the core clock
  assign brownout_det    = uv_req;
  assign lp_brownout_det = lp_uv_req;
endmodule // reset_far_side_model

// *** sim/reset_source_control_tb.sv ***
// Self-checking bench for the reset source controller.
`timescale 1ns/1ps

module reset_source_control_tb;
  import reset_source_pkg::*;
  localparam int PW = 20;
  localparam int FL = 4;
  localparam logic [3:0] PCS = OFS_POWER_CONTROL_STATUS;
  localparam logic [3:0] CST = OFS_CORE_STATUS;

  typedef struct packed {
    logic [4:0] ev;
    logic       sre;
    logic       rs;
    logic [7:0] pcs;
    logic [7:0] cs;
  } row_type;

  // ==========================================================
  // Signals
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
  logic        wb_ack_o;
  logic [1:0]  brownout_enable_cfg = 2'h1;
  logic        low_power_brownout_cfg_n = 1'b1, ext_reset_pin_enable = 1'b1;
  logic        low_voltage_programming = 1'b0, stack_reset_enable = 1'b1;
  logic        powerup_timer_enable_n = 1'b0, sleep_active = 1'b0;
  logic        brownout_detect, low_power_brownout_detect;
  logic        external_reset_pin_i, external_reset_pin_o;
  logic        external_reset_pin_oe, external_reset_pin_pullup;
  logic        watchdog_timeout = 1'b0, watchdog_clear_instr = 1'b0;
  logic        reset_instr_exec = 1'b0, stack_overflow = 1'b0;
  logic        stack_underflow = 1'b0, programming_mode = 1'b0;
  logic        core_reset_o, pin_low = 1'b0, uv = 1'b0, lp_uv = 1'b0;
  int          fails = 0, n_checks = 0, cyc_cnt = 0, n;

  // Events: watchdog, instr, over, under, clear
  row_type rows [6] = '{
    '{5'h10, 1'b1, 1'b1, 8'h07, 8'h08},
    '{5'h08, 1'b1, 1'b1, 8'h03, 8'h18},
    '{5'h04, 1'b1, 1'b1, 8'h87, 8'h18},
    '{5'h02, 1'b1, 1'b1, 8'h47, 8'h18},
    '{5'h11, 1'b1, 1'b0, 8'h07, 8'h18},
    '{5'h04, 1'b0, 1'b0, 8'h07, 8'h18}
  };

  always #12.5 core_clk = ~core_clk;

  reset_source_control #(.PWRT_LEN(PW), .FILTER_LEN(FL))
    reset_source_control_inst (
    .core_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .brownout_enable_cfg,
    .low_power_brownout_cfg_n, .ext_reset_pin_enable,
    .low_voltage_programming, .stack_reset_enable, .powerup_timer_enable_n,
    .brownout_detect, .low_power_brownout_detect, .external_reset_pin_i,
    .external_reset_pin_o, .external_reset_pin_oe, .external_reset_pin_pullup,
    .sleep_active, .watchdog_timeout, .watchdog_clear_instr,
    .reset_instr_exec, .stack_overflow, .stack_underflow, .programming_mode,
    .core_reset_o);

  reset_far_side_model reset_far_side_model_inst (
    .core_clk(core_clk), .pin_low_req(pin_low), .uv_req(uv),
    .lp_uv_req(lp_uv), .pin_pullup(external_reset_pin_pullup),
    .pin_oe(external_reset_pin_oe), .pin_o(external_reset_pin_o),
    .pin_level(external_reset_pin_i), .brownout_det(brownout_detect),
    .lp_brownout_det(low_power_brownout_detect));

  // ==========================================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask

  task automatic wb(input logic we, input logic [3:0] a, input logic [7:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h00_0000, d};
    @(posedge core_clk);
    while (wb_ack_o !== 1'b1) @(posedge core_clk);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rchk(input logic [3:0] a, input logic [7:0] e, string nm);
    wb(1'b0, a, 8'h00);
    chk(nm, rd, {24'h00_0000, e});
  endtask

  task automatic pulse(input logic [4:0] ev);
    {watchdog_timeout, reset_instr_exec, stack_overflow, stack_underflow,
     watchdog_clear_instr} <= ev;
    @(posedge core_clk);
    {watchdog_timeout, reset_instr_exec, stack_overflow, stack_underflow,
     watchdog_clear_instr} <= 5'h00;
    @(posedge core_clk);
  endtask

  task automatic wait_run();
    n = 0;
    while (core_reset_o !== 1'b0) begin
      @(posedge core_clk);
      n++;
    end
  endtask

  task automatic quiet(input int k, input string nm);
    logic seen;
    seen = 1'b0;
    repeat (k) begin
      @(posedge core_clk);
      seen = seen | core_reset_o;
    end
    chk(nm, 32'(seen), 32'd0);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Whole run is a few hundred cycles
  always @(posedge core_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      fails++;
      wrap_up();
    end
  end

  // ==========================================================
  // Sequence
  initial begin
    cyc(8);
    rst <= 1'b0;
    @(posedge core_clk);
    wait_run();
    chk("power-up delay", 32'(n >= PW), 32'd1);
    rchk(PCS, 8'h04, "pcs after reset");
    rchk(CST, 8'h18, "core_status after reset");
    rchk(OFS_PIN_CTRL, 8'h06, "pin_ctrl after reset");
    wb(1'b1, CST, 8'h00);
    rchk(CST, 8'h18, "core_status read-only");
    wb_sel_i <= 4'h0;
    wb(1'b1, PCS, 8'h07);
    wb_sel_i <= 4'h1;
    rchk(PCS, 8'h04, "sel ignored");
    rchk(4'hC, 8'h00, "unmapped");
    chk("pin oe", 32'(external_reset_pin_oe), 32'd0);
    chk("pin pullup", 32'(external_reset_pin_pullup), 32'd1);
    $display("end of test reset");
    foreach (rows[i]) begin
      stack_reset_enable <= rows[i].sre;
      wb(1'b1, PCS, 8'h07);
      pulse(5'h01);
      pulse(rows[i].ev);
      chk("event reset", 32'(core_reset_o), 32'(rows[i].rs));
      if (rows[i].rs) begin
        cyc(9);
        chk("settle", 32'(core_reset_o), 32'd1);
        wait_run();
      end
      rchk(PCS, rows[i].pcs, "pcs");
      rchk(CST, rows[i].cs, "core_status");
    end
    $display("end of test events");
    pin_low <= 1'b1;
    cyc(2);
    pin_low <= 1'b0;
    quiet(12, "short pulse");
    pin_low <= 1'b1;
    cyc(12);
    chk("pin held", 32'(core_reset_o), 32'd1);
    chk("pin driven", 32'(external_reset_pin_oe), 32'd0);
    chk("pin out", 32'(external_reset_pin_o), 32'd0);
    pin_low <= 1'b0;
    @(posedge core_clk);
    wait_run();
    chk("pin settle", 32'(n >= 10), 32'd1);
    $display("end of test pin");
    lp_uv <= 1'b1;
    quiet(10, "low-power off");
    wb(1'b1, PCS, 8'h07);
    brownout_enable_cfg <= BROWNOUT_OFF;
    low_power_brownout_cfg_n <= 1'b0;
    pin_low <= 1'b1;
    cyc(4);
    chk("lp brownout", 32'(core_reset_o), 32'd1);
    lp_uv <= 1'b0;
    cyc(PW + 20);
    pin_low <= 1'b0;
    @(posedge core_clk);
    wait_run();
    chk("late pin", 32'(n >= 10 && n <= FL + 18), 32'd1);
    rchk(PCS, 8'h06, "lp brownout flag");
    wb(1'b1, PCS, 8'h07);
    brownout_enable_cfg <= 2'h1;
    uv <= 1'b1;
    cyc(4);
    uv <= 1'b0;
    wait_run();
    chk("timer on", 32'(n >= PW + 10), 32'd1);
    rchk(PCS, 8'h06, "brownout flag");
    powerup_timer_enable_n <= 1'b1;
    uv <= 1'b1;
    cyc(4);
    uv <= 1'b0;
    wait_run();
    chk("timer off", 32'(n < PW + 10), 32'd1);
    brownout_enable_cfg <= BROWNOUT_OFF_SLEEP;
    sleep_active <= 1'b1;
    uv <= 1'b1;
    quiet(8, "off in sleep");
    uv <= 1'b0;
    cyc(3);
    sleep_active <= 1'b0;
    $display("end of test brownout");
    wb(1'b1, OFS_PIN_CTRL, 8'h01);
    ext_reset_pin_enable <= 1'b0;
    cyc(2);
    rchk(OFS_PIN_CTRL, 8'h03, "plain input");
    pin_low <= 1'b1;
    quiet(20, "pin function off");
    pin_low <= 1'b0;
    cyc(FL + 4);
    wb(1'b1, OFS_PIN_CTRL, 8'h00);
    chk("soft pullup", 32'(external_reset_pin_pullup), 32'd0);
    low_voltage_programming <= 1'b1;
    quiet(FL + 4, "programming pin on");
    chk("pin fn pullup", 32'(external_reset_pin_pullup), 32'd1);
    rchk(OFS_PIN_CTRL, 8'h06, "pin fn on");
    $display("end of test pin config");
    powerup_timer_enable_n <= 1'b0;
    wb(1'b1, PCS, 8'h87);
    programming_mode <= 1'b1;
    cyc(5);
    chk("prog hold", 32'(core_reset_o), 32'd1);
    programming_mode <= 1'b0;
    wait_run();
    chk("prog exit", 32'(n >= PW), 32'd1);
    rchk(PCS, 8'h04, "prog pcs");
    rchk(CST, 8'h18, "prog core_status");
    $display("end of test programming exit");
    wrap_up();
  end
endmodule // reset_source_control_tb

// *** src/reset_source_control.sv ***
// Reset source combiner, start-up sequencer and cause flags.
//
// The register addresses and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps

// Summary of operation
// - Brown-out from low-power detector holds reset and marks brown-out flag.
// - One brown-out flag serves both normal and low-power detectors.
// - Configuration bit enables low-power detector; erased value disables it.
// - Pin reset function off only when pin-enable and programming bits zero.
// - Enabled reset pin held low keeps the device in reset.
// - Weak pull-up stays on while the pin reset function is enabled.
// - Short low pulses on the reset pin are filtered out.
// - Internal resets never drive the reset pin; it is input only.
// - Disabled pin is a plain input with software-controlled pull-up.
// - Watchdog expiry without clear resets and marks expiry flags.
// - Reset instruction resets the device and clears its flag to 0.
// - Stack overflow or underflow resets and sets the matching flag.
// - Stack resets happen only when stack reset enable is set.
// - Leaving programming mode behaves like a power-on reset but keeps the pin_ctrl pull-up bit.
// - Power-up timer delays start after power-on or brown-out if enabled.
// - Start waits for power-up timer and for pin release if enabled.
// - Timer runs apart from pin; start follows the filtered pin release by 10 settle cycles.
module reset_source_control
  import reset_source_pkg::*;
#(
  parameter int PWRT_LEN   = reset_source_pkg::PWRT_CYCLES,
  parameter int FILTER_LEN = reset_source_pkg::FILTER_CYCLES
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Configuration word bits
  input  wire logic [1:0]  brownout_enable_cfg,
  input  wire logic        low_power_brownout_cfg_n,
  input  wire logic        ext_reset_pin_enable,
  input  wire logic        low_voltage_programming,
  input  wire logic        stack_reset_enable,
  input  wire logic        powerup_timer_enable_n,
  // Supply monitors, asynchronous
  input  wire logic        brownout_detect,
  input  wire logic        low_power_brownout_detect,
  // External reset pin
  input  wire logic        external_reset_pin_i,
  output logic             external_reset_pin_o,
  output logic             external_reset_pin_oe,
  output logic             external_reset_pin_pullup,
  // Core events, same clock
  input  wire logic        sleep_active,
  input  wire logic        watchdog_timeout,
  input  wire logic        watchdog_clear_instr,
  input  wire logic        reset_instr_exec,
  input  wire logic        stack_overflow,
  input  wire logic        stack_underflow,
  input  wire logic        programming_mode,
  // Core reset
  output logic             core_reset_o
);

  localparam int PW = $clog2(PWRT_LEN + 1);
  localparam int FW = $clog2(FILTER_LEN + 1);
  localparam int SW = $clog2(SETTLE_CYCLES + 1);

  if (PWRT_LEN < 1 || FILTER_LEN < 2) begin : g_bad_params
    $error("reset_source_control: PWRT_LEN>=1 and FILTER_LEN>=2 needed");
  end

  // ===========================================================
  // Input synchronisers
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1_q <= 3'h4;
      sync2_q <= 3'h4;
    end else begin
      sync1_q <= {external_reset_pin_i, low_power_brownout_detect,
                  brownout_detect};
      sync2_q <= sync1_q;
    end
  end

  logic pin_sync;
  logic normal_det_on;
  logic supply_low;
  logic pin_fn_en;
  assign pin_sync = sync2_q[2];
  // Off-in-sleep setting ignores the normal detector while asleep
  assign normal_det_on = (brownout_enable_cfg != BROWNOUT_OFF) &&
                         !((brownout_enable_cfg == BROWNOUT_OFF_SLEEP) &&
                           sleep_active);
  assign supply_low = (normal_det_on && sync2_q[0]) ||
                      (!low_power_brownout_cfg_n && sync2_q[1]);
  assign pin_fn_en = ext_reset_pin_enable || low_voltage_programming;

  // ===========================================================
  // Pin noise filter
  logic          filt_q;
  logic          filt_d;
  logic [FW-1:0] filt_cnt_q;
  logic [FW-1:0] filt_cnt_d;

  always_comb begin
    filt_d     = filt_q;
    filt_cnt_d = '0;
    if (pin_sync != filt_q) begin
      // Level must persist for FILTER_LEN cycles before it is believed
      if (filt_cnt_q == FW'(FILTER_LEN - 1)) begin
        filt_d = pin_sync;
      end else begin
        filt_cnt_d = filt_cnt_q + FW'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      filt_q     <= 1'b1;
      filt_cnt_q <= '0;
    end else begin
      filt_q     <= filt_d;
      filt_cnt_q <= filt_cnt_d;
    end
  end

  logic pin_low;
  assign pin_low = pin_fn_en && !filt_q;

  // ===========================================================
  // Event decode
  logic prog_q;
  logic prog_exit;
  logic dog_event;
  logic stk_over_ev;
  logic stk_under_ev;
  logic soft_event;

  assign prog_exit    = prog_q && !programming_mode;
  assign dog_event    = watchdog_timeout && !watchdog_clear_instr;
  assign stk_over_ev  = stack_overflow && stack_reset_enable;
  assign stk_under_ev = stack_underflow && stack_reset_enable;
  assign soft_event   = dog_event || reset_instr_exec ||
                        stk_over_ev || stk_under_ev;

  // ===========================================================
  // Start-up sequencer
  seq_state_type state_q;
  seq_state_type state_d;
  logic [PW-1:0] pwrt_cnt_q;
  logic [PW-1:0] pwrt_cnt_d;
  logic [SW-1:0] settle_cnt_q;
  logic [SW-1:0] settle_cnt_d;

  always_comb begin
    state_d      = state_q;
    pwrt_cnt_d   = pwrt_cnt_q;
    settle_cnt_d = '0;
    if (supply_low || programming_mode) begin
      state_d    = ST_HOLD;
      pwrt_cnt_d = '0;
    end else if (soft_event) begin
      state_d = ST_WAIT_PIN;
    end else begin
      unique case (state_q)
        ST_HOLD: begin
          state_d = powerup_timer_enable_n ? ST_WAIT_PIN : ST_PWRT;
        end
        ST_PWRT: begin
          // Counts regardless of the pin level
          if (pwrt_cnt_q == PW'(PWRT_LEN - 1)) begin
            state_d = ST_WAIT_PIN;
          end else begin
            pwrt_cnt_d = pwrt_cnt_q + PW'(1);
          end
        end
        ST_WAIT_PIN: begin
          if (!pin_low) begin
            state_d = ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (pin_low) begin
            state_d = ST_WAIT_PIN;
          end else if (settle_cnt_q == SW'(SETTLE_CYCLES - 1)) begin
            state_d = ST_RUN;
          end else begin
            settle_cnt_d = settle_cnt_q + SW'(1);
          end
        end
        ST_RUN: begin
          if (pin_low) begin
            state_d = ST_WAIT_PIN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q      <= ST_HOLD;
      pwrt_cnt_q   <= '0;
      settle_cnt_q <= '0;
      prog_q       <= 1'b0;
      core_reset_o <= 1'b1;
    end else begin
      state_q      <= state_d;
      pwrt_cnt_q   <= pwrt_cnt_d;
      settle_cnt_q <= settle_cnt_d;
      prog_q       <= programming_mode;
      core_reset_o <= (state_d != ST_RUN);
    end
  end

  // ===========================================================
  // Wishbone slave, one wait state
  logic        ack_q;
  logic        wr_en;
  logic        wr_pcs;
  logic        wr_pin;
  logic [31:0] rdata;
  logic [31:0] rdata_q;

  assign wr_en  = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0];
  assign wr_pcs = wr_en && (wb_adr_i == OFS_POWER_CONTROL_STATUS);
  assign wr_pin = wr_en && (wb_adr_i == OFS_PIN_CTRL);

  // ===========================================================
  // Cause flags
  logic brown_n_q, brown_n_d, por_n_q, por_n_d, instr_n_q, instr_n_d;
  logic ovf_q, ovf_d, unf_q, unf_d, exp_q, exp_d, pwrdn_q, pwrdn_d;
  logic pullup_en_q, pullup_en_d;

  always_comb begin
    {brown_n_d, por_n_d, instr_n_d} = {brown_n_q, por_n_q, instr_n_q};
    {ovf_d, unf_d, exp_d, pwrdn_d} = {ovf_q, unf_q, exp_q, pwrdn_q};
    pullup_en_d = pullup_en_q;
    if (wr_pcs) begin
      brown_n_d = wb_dat_i[PCS_BROWNOUT_N];
      por_n_d   = wb_dat_i[PCS_POWER_ON_N];
      instr_n_d = wb_dat_i[PCS_RESET_INSTR];
      unf_d     = wb_dat_i[PCS_STACK_UNDER];
      ovf_d     = wb_dat_i[PCS_STACK_OVER];
    end
    if (wr_pin) begin
      pullup_en_d = wb_dat_i[PIN_PULLUP_EN];
    end
    // Hardware events win over a same-cycle software write
    if (watchdog_clear_instr) begin
      exp_d   = 1'b1;
      pwrdn_d = 1'b1;
    end
    if (prog_exit) begin
      // Power-on values: instruction, expiry and power-down flags read 1
      {brown_n_d, por_n_d, instr_n_d} = 3'h1;
      {ovf_d, unf_d, exp_d, pwrdn_d} = 4'h3;
    end
    if (supply_low) begin
      brown_n_d = 1'b0;
    end
    if (dog_event) begin
      exp_d   = 1'b0;
      pwrdn_d = 1'b1;
    end
    if (reset_instr_exec) begin
      instr_n_d = 1'b0;
    end
    if (stk_over_ev) begin
      ovf_d = 1'b1;
    end
    if (stk_under_ev) begin
      unf_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      {brown_n_q, por_n_q, instr_n_q} <= 3'h1;
      {ovf_q, unf_q, exp_q, pwrdn_q} <= 4'h3;
      pullup_en_q <= 1'b0;
    end else begin
      {brown_n_q, por_n_q, instr_n_q} <= {brown_n_d, por_n_d, instr_n_d};
      {ovf_q, unf_q, exp_q, pwrdn_q} <= {ovf_d, unf_d, exp_d, pwrdn_d};
      pullup_en_q <= pullup_en_d;
    end
  end

  // ===========================================================
  // Read mux and ack
  always_comb begin
    rdata = '0;
    unique case (wb_adr_i)
      OFS_POWER_CONTROL_STATUS: begin
        rdata[PCS_BROWNOUT_N]  = brown_n_q;
        rdata[PCS_POWER_ON_N]  = por_n_q;
        rdata[PCS_RESET_INSTR] = instr_n_q;
        rdata[PCS_STACK_UNDER] = unf_q;
        rdata[PCS_STACK_OVER]  = ovf_q;
      end
      OFS_CORE_STATUS: begin
        rdata[CST_POWERDOWN] = pwrdn_q;
        rdata[CST_EXPIRY]    = exp_q;
      end
      OFS_PIN_CTRL: begin
        rdata[PIN_PULLUP_EN] = pullup_en_q;
        rdata[PIN_LEVEL]     = pin_sync;
        rdata[PIN_RESET_FN]  = pin_fn_en;
      end
      default: rdata = '0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ack_q   <= 1'b0;
      rdata_q <= '0;
    end else begin
      ack_q   <= wb_cyc_i && wb_stb_i && !ack_q;
      rdata_q <= rdata;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // ===========================================================
  // Pin drivers: input only, pull-up owner depends on function
  assign external_reset_pin_o      = 1'b0;
  assign external_reset_pin_oe     = 1'b0;
  assign external_reset_pin_pullup =
    pin_fn_en ? 1'b1 : pullup_en_q;

  // ===========================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_pin_input_only: assert property (!external_reset_pin_oe)
    else $error("reset pin driven");
  a_pullup_owner: assert property (
      external_reset_pin_pullup == (pin_fn_en || pullup_en_q))
    else $error("pull-up control wrong");
  a_pin_holds_reset: assert property (
      pin_low && !prog_exit |=> core_reset_o && state_q != ST_RUN)
    else $error("pin low did not hold reset");
  a_filter_persist: assert property (
      $changed(filt_q) |-> $past(filt_cnt_q) == FW'(FILTER_LEN - 1))
    else $error("filter changed too early");
  a_brownout_flag: assert property (
      supply_low |=> core_reset_o && !brown_n_q)
    else $error("brown-out not recorded");
  a_lowpower_off: assert property (
      low_power_brownout_cfg_n && !normal_det_on |-> !supply_low)
    else $error("disabled low-power detector acted");
  a_watchdog_flags: assert property (
      dog_event && !supply_low && !programming_mode
      |=> !exp_q && pwrdn_q && state_q == ST_WAIT_PIN)
    else $error("watchdog reset not recorded");
  a_reset_instr: assert property (
      reset_instr_exec && !prog_exit |=> !instr_n_q && core_reset_o)
    else $error("reset instruction not recorded");
  a_stack_reset: assert property (
      stack_overflow && stack_reset_enable && !prog_exit
      |=> ovf_q && core_reset_o)
    else $error("stack overflow not recorded");
  a_stack_gated: assert property (
      !stack_reset_enable && !wr_pcs && !prog_exit
      |=> !$rose(ovf_q) && !$rose(unf_q))
    else $error("stack flag set while disabled");
  a_prog_exit_por: assert property (
      prog_exit && !supply_low && !soft_event
      |=> !por_n_q && state_q == ($past(powerup_timer_enable_n) ?
      ST_WAIT_PIN : ST_PWRT))
    else $error("programming exit not like power-on");
  a_run_settled: assert property (
      $fell(core_reset_o)
      |-> $past(state_q, 10) == ST_SETTLE && !pin_low)
    else $error("start without settle");
  a_flags_kept: assert property (
      dog_event && !wr_pcs && !prog_exit && !supply_low && !reset_instr_exec
      |=> $stable(brown_n_q) && $stable(instr_n_q))
    else $error("cause flag lost");

  c_watchdog_reset: cover property (dog_event ##[1:40] $fell(core_reset_o));
  c_pwrt_to_run: cover property (state_q == ST_PWRT ##1
      state_q == ST_WAIT_PIN ##[1:20] state_q == ST_RUN);
  c_pin_late: cover property (state_q == ST_WAIT_PIN && pin_low
      ##[1:50] state_q == ST_SETTLE);
  c_stack_reset: cover property (stk_under_ev ##1 unf_q);

endmodule // reset_source_control

// *** src/reset_source_pkg.sv ***
// Constants shared by the reset source controller and its bench.
package reset_source_pkg;

  // ===========================================================
  // Timing
  localparam int CLK_PERIOD_NS   = 25;
  localparam int PWRT_TIME_NS    = 64000;
  localparam int PWRT_CYCLES     =
    (PWRT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILTER_TIME_NS  = 200;
  localparam int FILTER_CYCLES   =
    (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYCLES   = 10;

  // ===========================================================
  // Register byte offsets
  localparam logic [3:0] OFS_POWER_CONTROL_STATUS = 4'h0;
  localparam logic [3:0] OFS_CORE_STATUS          = 4'h4;
  localparam logic [3:0] OFS_PIN_CTRL             = 4'h8;

  // ===========================================================
  // power_control_status fields
  localparam int PCS_BROWNOUT_N  = 0;
  localparam int PCS_POWER_ON_N  = 1;
  localparam int PCS_RESET_INSTR = 2;
  localparam int PCS_STACK_UNDER = 6;
  localparam int PCS_STACK_OVER  = 7;

  // core_status fields
  localparam int CST_POWERDOWN   = 3;
  localparam int CST_EXPIRY      = 4;

  // pin_ctrl fields
  localparam int PIN_PULLUP_EN   = 0;
  localparam int PIN_LEVEL       = 1;
  localparam int PIN_RESET_FN    = 2;

  // ===========================================================
  // Brown-out enable setting codes
  localparam logic [1:0] BROWNOUT_OFF       = 2'h0;
  localparam logic [1:0] BROWNOUT_OFF_SLEEP = 2'h2;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_HOLD, ST_PWRT, ST_WAIT_PIN, ST_SETTLE, ST_RUN
  } seq_state_type;

endpackage : reset_source_pkg
